// *** logic/acl_pkg.sv ***
package acl_pkg;
  localparam int BYTE_W   = 8;
  localparam int ADDR_W   = 16;
  localparam int SHIFT_W  = 16;
  localparam int MWORD_W  = 16;
  // shifter byte lanes
  localparam int SH_LO_LSB = 0;
  localparam int SH_MID_LSB = 8;
  localparam int SH_HI_LSB = 8;
  // micro word field positions, bit 1 of the word is index MWORD_W-1
  localparam int IMM_LSB  = 0;
  localparam int CTL_LSB  = 12;
  localparam logic [3:0] CTL_IMM_ONLY = 4'he;
  localparam logic [3:0] CTL_SHIFT_IMM = 4'hc;
  localparam logic [7:0] CNT_ALL_ONES = 8'hff;
  localparam logic [7:0] CNT_ONE      = 8'h01;

  typedef struct packed {
    logic addr_low_strobe_en;
    logic shifter_source_sel;
    logic base_a_strobe_en;
    logic base_b_strobe_en;
    logic count_step_en;
    logic count_load_en;
  } acl_ctrl_t;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } acl_word_t;
endpackage

// *** logic/acl_imm_decode.sv ***
`timescale 1ns/1ns
module acl_imm_decode (
  input  wire logic [3:0] ctl_bits_in,   // first four control bits of micro word
  output logic            imm_load_out   // transfer strobe for immediate reg
);
  // true for codes 1110 and 1100
  assign imm_load_out = (ctl_bits_in == acl_pkg::CTL_IMM_ONLY) ||
                        (ctl_bits_in == acl_pkg::CTL_SHIFT_IMM);
endmodule // acl_imm_decode

// *** logic/acl_addr_regs.sv ***
`timescale 1ns/1ns
module acl_addr_regs (
  input  wire logic               clk_sys_in,          // 250 MHz system clock
  input  wire logic               nrst_in,             // async reset, active low
  input  wire logic               phase_three_clock_in,// one-cycle phase-3 enable
  input  wire logic               system_clock_gated_in,// one-cycle system-clock enable
  input  wire acl_pkg::acl_ctrl_t ctrl_in,             // nanocode strobe/select bits
  input  wire logic [15:0]        shifter_out_in,      // shifter output word
  input  wire logic [15:0]        micro_store_in,      // current micro word, bit1 at msb
  input  wire logic               base_b_pick_in,      // select base B onto address
  input  wire logic               count_test_in,       // condition test of counter
  output logic [15:0]             full_addr_bus_out,   // base byte : low byte
  output logic [7:0]              port_base_out,       // base byte to port selector
  output logic [7:0]              y_low_out,           // low-address to Y low byte
  output logic [15:0]             combined_op_out,     // counter : immediate
  output logic [7:0]              x_high_out,          // counter to X high byte
  output logic [7:0]              y_high_out,          // counter to Y high byte
  output logic                    count_wrap_flag_out, // counter wrap flag
  output logic                    imm_load_from_store_out // decoded transfer, registered
);
  logic [7:0] addr_low_reg_r;
  logic [7:0] base_reg_a_r;
  logic [7:0] base_reg_b_r;
  logic [7:0] immediate_byte_reg_r;
  logic [7:0] loop_count_reg_r;
  logic       count_wrap_flag_r;
  logic       imm_xfer;
  logic [7:0] src_byte;
  logic [7:0] base_sel;
  logic       addr_low_ld;
  logic       base_a_ld;
  logic       base_b_ld;
  logic       cnt_ld;
  logic       cnt_step;
  logic       imm_ld;
  logic [7:0] loop_count_nxt;
  logic       wrap_set;

  acl_imm_decode u_dec (
    .ctl_bits_in  (micro_store_in[acl_pkg::CTL_LSB +: 4]),
    .imm_load_out (imm_xfer)
  );

  // shared source mux, 1 picks shifter low byte
  assign src_byte = ctrl_in.shifter_source_sel ?
                    shifter_out_in[acl_pkg::SH_LO_LSB +: 8] :
                    immediate_byte_reg_r;
  // gated enables replace the original gated register clocks
  assign addr_low_ld = phase_three_clock_in & ctrl_in.addr_low_strobe_en;
  assign base_a_ld   = phase_three_clock_in & ctrl_in.base_a_strobe_en;
  assign base_b_ld   = phase_three_clock_in & ctrl_in.base_b_strobe_en;
  assign cnt_ld      = phase_three_clock_in & ctrl_in.count_load_en;
  assign cnt_step    = phase_three_clock_in & ctrl_in.count_step_en & ~ctrl_in.count_load_en;
  assign imm_ld      = system_clock_gated_in & imm_xfer;
  assign loop_count_nxt = cnt_ld ? src_byte :
                          cnt_step ? loop_count_reg_r + acl_pkg::CNT_ONE :
                          loop_count_reg_r;
  assign wrap_set = cnt_step && (loop_count_reg_r == acl_pkg::CNT_ALL_ONES);
  assign base_sel = base_b_pick_in ? base_reg_b_r : base_reg_a_r;

  // registers hold unless their enable is high
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      addr_low_reg_r <= 8'h00;
    end else if (addr_low_ld) begin
      addr_low_reg_r <= src_byte;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      base_reg_a_r <= 8'h00;
      base_reg_b_r <= 8'h00;
    end else begin
      if (base_a_ld) begin
        base_reg_a_r <= shifter_out_in[acl_pkg::SH_MID_LSB +: 8];
      end
      if (base_b_ld) begin
        base_reg_b_r <= shifter_out_in[acl_pkg::SH_HI_LSB +: 8];
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      immediate_byte_reg_r <= 8'h00;
    end else if (imm_ld) begin
      immediate_byte_reg_r <= micro_store_in[acl_pkg::IMM_LSB +: 8];
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      loop_count_reg_r <= 8'h00;
    end else begin
      loop_count_reg_r <= loop_count_nxt;
    end
  end

  // wrap can only set on a step, never with a load; a set wins over a count_test_in clear in the same cycle
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count_wrap_flag_r <= 1'b0;
    end else if (wrap_set) begin
      count_wrap_flag_r <= 1'b1;
    end else if (cnt_ld || count_test_in) begin
      count_wrap_flag_r <= 1'b0;
    end
  end

  // outputs registered one cycle behind the internal state
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      full_addr_bus_out       <= 16'h0000;
      port_base_out           <= 8'h00;
      y_low_out               <= 8'h00;
      combined_op_out         <= 16'h0000;
      x_high_out              <= 8'h00;
      y_high_out              <= 8'h00;
      count_wrap_flag_out     <= 1'b0;
      imm_load_from_store_out <= 1'b0;
    end else begin
      full_addr_bus_out       <= {base_sel, addr_low_reg_r};
      port_base_out           <= base_sel;
      y_low_out               <= addr_low_reg_r;
      combined_op_out         <= {loop_count_reg_r, immediate_byte_reg_r};
      x_high_out              <= loop_count_reg_r;
      y_high_out              <= loop_count_reg_r;
      count_wrap_flag_out     <= count_wrap_flag_r;
      imm_load_from_store_out <= imm_xfer;
    end
  end

  property p_low_load;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      addr_low_ld |=> addr_low_reg_r == $past(src_byte);
  endproperty
  a_low_load: assert property (p_low_load) else $error("low address load wrong");

  property p_low_hold;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      !addr_low_ld |=> $stable(addr_low_reg_r);
  endproperty
  a_low_hold: assert property (p_low_hold) else $error("low address changed without strobe");

  property p_base_a;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      base_a_ld |=> base_reg_a_r == $past(shifter_out_in[15:8]);
  endproperty
  a_base_a: assert property (p_base_a) else $error("base A load wrong");

  property p_base_b_hold;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      !base_b_ld |=> $stable(base_reg_b_r);
  endproperty
  a_base_b_hold: assert property (p_base_b_hold) else $error("base B changed without strobe");

  property p_addr_out;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      1'b1 |=> full_addr_bus_out ==
        {($past(base_b_pick_in) ? $past(base_reg_b_r) : $past(base_reg_a_r)),
         $past(addr_low_reg_r)};
  endproperty
  a_addr_out: assert property (p_addr_out) else $error("address bus mismatch");

  property p_load_wins;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      (cnt_ld && ctrl_in.count_step_en) |=> loop_count_reg_r == $past(src_byte);
  endproperty
  a_load_wins: assert property (p_load_wins) else $error("increment beat load");

  property p_step;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      cnt_step |=> loop_count_reg_r == $past(loop_count_reg_r) + 8'h01;
  endproperty
  a_step: assert property (p_step) else $error("counter step wrong");

  property p_wrap;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      wrap_set |=> count_wrap_flag_r && loop_count_reg_r == 8'h00 ##1 count_wrap_flag_out;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap flag not set");

  property p_wrap_clr;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      (cnt_ld && !wrap_set) |=> !count_wrap_flag_r;
  endproperty
  a_wrap_clr: assert property (p_wrap_clr) else $error("wrap flag not cleared");

  property p_imm;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      !imm_ld |=> $stable(immediate_byte_reg_r);
  endproperty
  a_imm: assert property (p_imm) else $error("immediate changed without transfer");

  property p_low_from_sh;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      (addr_low_ld && ctrl_in.shifter_source_sel) |=>
        addr_low_reg_r == $past(shifter_out_in[acl_pkg::SH_LO_LSB +: acl_pkg::BYTE_W]);
  endproperty
  a_low_from_sh: assert property (p_low_from_sh) else $error("low byte not shifter");

  property p_low_from_imm;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      (addr_low_ld && !ctrl_in.shifter_source_sel) |=>
        addr_low_reg_r == $past(immediate_byte_reg_r);
  endproperty
  a_low_from_imm: assert property (p_low_from_imm) else $error("low byte not imm");

  property p_base_a_hold;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      !base_a_ld |=> $stable(base_reg_a_r);
  endproperty
  a_base_a_hold: assert property (p_base_a_hold) else $error("base A moved");

  property p_base_b_load;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      base_b_ld |=>
        base_reg_b_r == $past(shifter_out_in[acl_pkg::SH_HI_LSB +: acl_pkg::BYTE_W]);
  endproperty
  a_base_b_load: assert property (p_base_b_load) else $error("base B load wrong");

  property p_no_phase;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      !phase_three_clock_in |=> $stable(addr_low_reg_r) && $stable(base_reg_a_r) &&
        $stable(base_reg_b_r) && $stable(loop_count_reg_r);
  endproperty
  a_no_phase: assert property (p_no_phase) else $error("held reg moved");

  property p_port_base;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      port_base_out == full_addr_bus_out[acl_pkg::ADDR_W-1 -: acl_pkg::BYTE_W];
  endproperty
  a_port_base: assert property (p_port_base) else $error("port base mismatch");

  property p_y_low;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      y_low_out == full_addr_bus_out[acl_pkg::BYTE_W-1:0];
  endproperty
  a_y_low: assert property (p_y_low) else $error("y low mismatch");

  property p_low_out;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      1'b1 |=> y_low_out == $past(addr_low_reg_r);
  endproperty
  a_low_out: assert property (p_low_out) else $error("low out stale");

  property p_pick_a;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      !base_b_pick_in |=> port_base_out == $past(base_reg_a_r);
  endproperty
  a_pick_a: assert property (p_pick_a) else $error("base A not on bus");

  property p_pick_b;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      base_b_pick_in |=> port_base_out == $past(base_reg_b_r);
  endproperty
  a_pick_b: assert property (p_pick_b) else $error("base B not on bus");

  property p_comb_hi;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      combined_op_out[acl_pkg::ADDR_W-1 -: acl_pkg::BYTE_W] == x_high_out;
  endproperty
  a_comb_hi: assert property (p_comb_hi) else $error("counter byte wrong");

  property p_comb_lo;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      1'b1 |=> combined_op_out[acl_pkg::BYTE_W-1:0] == $past(immediate_byte_reg_r);
  endproperty
  a_comb_lo: assert property (p_comb_lo) else $error("imm byte wrong");

  property p_xy_same;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      x_high_out == y_high_out;
  endproperty
  a_xy_same: assert property (p_xy_same) else $error("X and Y differ");

  property p_cnt_out;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      1'b1 |=> y_high_out == $past(loop_count_reg_r);
  endproperty
  a_cnt_out: assert property (p_cnt_out) else $error("counter out stale");

  property p_cnt_hold;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      (!cnt_ld && !cnt_step) |=> $stable(loop_count_reg_r);
  endproperty
  a_cnt_hold: assert property (p_cnt_hold) else $error("counter moved");

  property p_cnt_imm;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      (cnt_ld && !ctrl_in.shifter_source_sel) |=>
        loop_count_reg_r == $past(immediate_byte_reg_r);
  endproperty
  a_cnt_imm: assert property (p_cnt_imm) else $error("count not from imm");

  property p_cnt_sh;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      (cnt_ld && ctrl_in.shifter_source_sel) |=>
        loop_count_reg_r == $past(shifter_out_in[acl_pkg::SH_LO_LSB +: acl_pkg::BYTE_W]);
  endproperty
  a_cnt_sh: assert property (p_cnt_sh) else $error("count not shifter");

  property p_test_clr;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      (count_test_in && !wrap_set) |=> !count_wrap_flag_r;
  endproperty
  a_test_clr: assert property (p_test_clr) else $error("test kept flag");

  property p_wrap_only;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      (!count_wrap_flag_r && !wrap_set) |=> !count_wrap_flag_r;
  endproperty
  a_wrap_only: assert property (p_wrap_only) else $error("flag rose alone");

  property p_flag_out;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      1'b1 |=> count_wrap_flag_out == $past(count_wrap_flag_r);
  endproperty
  a_flag_out: assert property (p_flag_out) else $error("flag out stale");

  property p_imm_load;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      imm_ld |=>
        immediate_byte_reg_r == $past(micro_store_in[acl_pkg::IMM_LSB +: acl_pkg::BYTE_W]);
  endproperty
  a_imm_load: assert property (p_imm_load) else $error("imm load wrong");

  property p_dec_out;
    @(posedge clk_sys_in) disable iff (!nrst_in)
      1'b1 |=> imm_load_from_store_out ==
        ($past(micro_store_in[acl_pkg::CTL_LSB +: 4]) == acl_pkg::CTL_IMM_ONLY ||
         $past(micro_store_in[acl_pkg::CTL_LSB +: 4]) == acl_pkg::CTL_SHIFT_IMM);
  endproperty
  a_dec_out: assert property (p_dec_out) else $error("decode out wrong");
endmodule // acl_addr_regs

// *** bench/acl_nano_seq.sv ***
`timescale 1ns/1ns
module acl_nano_seq (
  input  wire logic          clk_in,       // system clock
  output logic               phase_out,    // phase-3 enable
  output logic               sys_gate_out, // immediate load enable
  output acl_pkg::acl_ctrl_t ctrl_out,     // nanocode strobe bits
  output logic [15:0]        shifter_out,  // shifter word
  output logic [15:0]        micro_out     // micro word
);
  initial begin
    phase_out = 1'h0;
    sys_gate_out = 1'h0;
    ctrl_out = acl_pkg::acl_ctrl_t'(6'h00);
    shifter_out = 16'h0000;
    micro_out = 16'h0000;
  end
  // one nanocode step, held across exactly one sampling edge
  task automatic op(input logic ph, input logic [5:0] c, input logic [15:0] sh);
    @(posedge clk_in);
    #1;
    phase_out = ph;
    ctrl_out = acl_pkg::acl_ctrl_t'(c);
    shifter_out = sh;
    @(posedge clk_in);
    #1;
    phase_out = 1'h0;
    ctrl_out = acl_pkg::acl_ctrl_t'(6'h00);
    shifter_out = ~sh; // released bus must not keep a stale value
  endtask
  // word settles a cycle before the pulse, so a registered decode sees it too
  task automatic imm(input logic [15:0] w);
    @(posedge clk_in);
    #1;
    micro_out = w;
    @(posedge clk_in);
    #1;
    sys_gate_out = 1'h1;
    @(posedge clk_in);
    #1;
    sys_gate_out = 1'h0;
    micro_out = ~w;
  endtask
endmodule // acl_nano_seq

// *** bench/address_counter_literal_regs_tb.sv ***
`timescale 1ns/1ns
module address_counter_literal_regs_tb;
  logic clk_sys_in, nrst_in, ph, sg, pick, ctest, flag, dec;
  acl_pkg::acl_ctrl_t ctrl;
  logic [15:0] sh, mw, full, comb;
  logic [7:0] port, ylo, xhi, yhi;
  int miscompares;
  int tests_run;
  logic [15:0] words [4] = '{16'he0a5, 16'hf03c, 16'hc05a, 16'hd011};
  logic [7:0] exps [4] = '{8'ha5, 8'ha5, 8'h5a, 8'h5a};
  logic dexp [4] = '{1'h1, 1'h0, 1'h1, 1'h0};
  acl_nano_seq seq_inst (.clk_in(clk_sys_in), .phase_out(ph), .sys_gate_out(sg),
    .ctrl_out(ctrl), .shifter_out(sh), .micro_out(mw));
  acl_addr_regs acl_addr_regs_inst (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .phase_three_clock_in(ph), .system_clock_gated_in(sg), .ctrl_in(ctrl),
    .shifter_out_in(sh), .micro_store_in(mw), .base_b_pick_in(pick),
    .count_test_in(ctest), .full_addr_bus_out(full), .port_base_out(port),
    .y_low_out(ylo), .combined_op_out(comb), .x_high_out(xhi), .y_high_out(yhi),
    .count_wrap_flag_out(flag), .imm_load_from_store_out(dec));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic settle;
    @(posedge clk_sys_in);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ac(input logic [15:0] e);
    settle();
    settle();
    chk(full, e);
    chk({port, ylo}, e);
  endtask
  task automatic cc(input logic [7:0] e, input logic f);
    settle();
    settle();
    chk({xhi, yhi}, {e, e});
    chk({comb[15:8], 7'h00, flag}, {e, 7'h00, f});
  endtask
  initial begin
    clk_sys_in = 1'h0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    #20000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    nrst_in = 1'h0;
    pick = 1'h0;
    ctest = 1'h0;
    miscompares = 0;
    tests_run = 0;
    repeat (4) @(posedge clk_sys_in);
    #1;
    nrst_in = 1'h1;
    for (int i = 0; i < 4; i++) begin
      fork
        seq_inst.imm(words[i]);
        begin
          settle();
          settle();
          chk({15'h0000, dec}, {15'h0000, dexp[i]});
        end
      join
      settle();
      chk({8'h00, comb[7:0]}, {8'h00, exps[i]});
    end
    $display("test immediate done");
    seq_inst.op(1'h1, 6'h20, 16'hffff);
    ac(16'h005a);
    seq_inst.op(1'h1, 6'h30, 16'h1234);
    ac(16'h0034);
    seq_inst.op(1'h1, 6'h08, 16'h5678);
    ac(16'h5634);
    seq_inst.op(1'h1, 6'h04, 16'h9abc);
    ac(16'h5634);
    pick = 1'h1;
    ac(16'h9a34);
    seq_inst.op(1'h0, 6'h3c, 16'hdead);
    ac(16'h9a34);
    pick = 1'h0;
    ac(16'h5634);
    $display("test address done");
    seq_inst.op(1'h1, 6'h11, 16'h00ff);
    cc(8'hff, 1'h0);
    seq_inst.op(1'h1, 6'h02, 16'h0000);
    cc(8'h00, 1'h1);
    settle();
    ctest = 1'h1;
    settle();
    ctest = 1'h0;
    cc(8'h00, 1'h0);
    seq_inst.op(1'h1, 6'h11, 16'h00fe);
    cc(8'hfe, 1'h0);
    seq_inst.op(1'h1, 6'h02, 16'h0000);
    cc(8'hff, 1'h0);
    seq_inst.op(1'h1, 6'h02, 16'h0000);
    cc(8'h00, 1'h1);
    seq_inst.op(1'h1, 6'h03, 16'h0077);
    cc(8'h5a, 1'h0);
    seq_inst.op(1'h1, 6'h11, 16'h00ff);
    cc(8'hff, 1'h0);
    ctest = 1'h1;
    seq_inst.op(1'h1, 6'h02, 16'h0000);
    ctest = 1'h0;
    cc(8'h00, 1'h1);
    seq_inst.op(1'h0, 6'h03, 16'h0000);
    cc(8'h00, 1'h1);
    seq_inst.op(1'h1, 6'h01, 16'h0000);
    cc(8'h5a, 1'h0);
    $display("test counter done");
    report_and_stop();
  end
endmodule // address_counter_literal_regs_tb
